/* verilog/bit_ctl_pkg.sv */
// package with opcodes, fields, register map and carrier types for the bit and control decoder
package bit_ctl_pkg;

    // decoder sequencing states
    typedef enum logic [1:0] {
        ST_EXEC  = 2'b00,
        ST_FLUSH = 2'b01,
        ST_WORD2 = 2'b10,
        ST_SLEEP = 2'b11
    } state_t;

    // arithmetic status flags from the datapath
    typedef struct packed {
        logic neg;
        logic ovf;
        logic zero;
        logic carry;
    } flags_t;

    // control bundle to the core datapath
    typedef struct packed {
        logic        fileWe;
        logic [7:0]  fileAddr;
        logic        accessSel;
        logic [7:0]  fileWrData;
        logic        pcLoad;
        logic [20:0] pcTarget;
        logic        stackPush;
        logic        stackPop;
        logic [20:0] pushValue;
        logic        fastSave;
        logic        fastRestore;
        logic        wregLoad;
        logic [7:0]  wregValue;
        logic        highIrqEnableSet;
        logic        lowIrqEnableSet;
        logic        watchdogClear;
        logic        sleepEnter;
        logic        flagWrite;
        logic        timeOutFlag;
        logic        powerDownFlag;
        logic        decimalAdjust;
        logic        softReset;
        logic        prescalerClear;
        logic        nopCycle;
    } ctl_t;

    // instruction patterns
    localparam logic [15:0] PAT_BIT_CLEAR   = 16'b1001_????_????_????;
    localparam logic [15:0] PAT_BIT_SET     = 16'b1000_????_????_????;
    localparam logic [15:0] PAT_BIT_TOGGLE  = 16'b0111_????_????_????;
    localparam logic [15:0] PAT_SKIP_CLEAR  = 16'b1011_????_????_????;
    localparam logic [15:0] PAT_SKIP_SET    = 16'b1010_????_????_????;
    localparam logic [15:0] PAT_COND_BRANCH = 16'b1110_0???_????_????;
    localparam logic [15:0] PAT_CALL        = 16'b1110_110?_????_????;
    localparam logic [15:0] PAT_JUMP        = 16'b1110_1111_????_????;
    localparam logic [15:0] PAT_REL_BRANCH  = 16'b1101_0???_????_????;
    localparam logic [15:0] PAT_REL_CALL    = 16'b1101_1???_????_????;
    localparam logic [15:0] PAT_SECOND_WORD = 16'b1111_????_????_????;
    localparam logic [15:0] PAT_RET_LITERAL = 16'b0000_1100_????_????;
    localparam logic [15:0] PAT_IRQ_RETURN  = 16'b0000_0000_0001_000?;
    localparam logic [15:0] PAT_SUB_RETURN  = 16'b0000_0000_0001_001?;
    localparam logic [15:0] OP_NOP          = 16'h0000;
    localparam logic [15:0] OP_SLEEP        = 16'h0003;
    localparam logic [15:0] OP_WDT_CLEAR    = 16'h0004;
    localparam logic [15:0] OP_PUSH         = 16'h0005;
    localparam logic [15:0] OP_POP          = 16'h0006;
    localparam logic [15:0] OP_DEC_ADJUST   = 16'h0007;
    localparam logic [15:0] OP_SOFT_RESET   = 16'h00FF;

    // special file addresses in the access bank
    localparam logic [7:0] PORT_B_ADDR = 8'h81;
    localparam logic [7:0] TIMER0_ADDR = 8'hD6;

    // flag values after reset
    localparam logic FLAG_RESET = 1'b1;

    // register map, byte addresses
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STAT_OFS   = 8'h04;
    localparam logic [7:0] RETIRE_OFS = 8'h08;

    // control register fields
    localparam int          CTRL_EN_BIT   = 0;
    localparam int          CTRL_PSA_BIT  = 1;
    localparam int          CTRL_PRIO_BIT = 2;
    localparam logic [2:0]  CTRL_RESET    = 3'h1;

endpackage

/* verilog/cond_eval.sv */
// branch condition and bit test evaluation
`timescale 1ns/10ps
`default_nettype none

module cond_eval (
    // condition select and flags
    input  wire logic [2:0]            condSel,
    input  wire bit_ctl_pkg::flags_t   flags,
    // bit test operands
    input  wire logic [7:0]            testData,
    input  wire logic [2:0]            bitIdx,
    // results
    output logic                       condTrue,
    output logic                       bitIsSet
);
    import bit_ctl_pkg::*;

    // pick the flag, odd selects invert it
    always_comb begin
        logic flagVal;
        flagVal = 1'b0;
        unique case (condSel[2:1])
            2'b00: flagVal = flags.zero;
            2'b01: flagVal = flags.carry;
            2'b10: flagVal = flags.ovf;
            2'b11: flagVal = flags.neg;
        endcase
        condTrue = flagVal ^ condSel[0];
    end

    // selected bit of the operand
    assign bitIsSet = testData[bitIdx];

endmodule
`default_nettype wire

/* verilog/bit_ctl_decoder.sv */
// bit-oriented and control-flow instruction decoder with wishbone control registers
// Operation
// - skip-if-clear test skips next word when zero
// - skip-if-set test skips next word when one
// - eight conditional branches, two cycles when taken
// - call uses two words, optional fast save
// - absolute jump uses two words
// - lone 1111 word executes as one-cycle no-op
// - pop drops stack top, flags untouched
// - push next counter onto stack top
// - interrupt return re-enables interrupts, fast restore
// - literal return loads working register, pops
// - standby entry sets time-out, clears power-down
// - counter change or true test costs flush cycle
// - port read-modify-write reads pin levels
// - bit write to timer zero clears prescaler
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module bit_ctl_decoder (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // instruction stream
    input  wire logic                  instrValid,
    input  wire logic [15:0]           instrWord,
    input  wire logic [20:0]           pcNow,
    // datapath state
    input  wire bit_ctl_pkg::flags_t   flags,
    input  wire logic [7:0]            fileRdData,
    input  wire logic [7:0]            portPins,
    input  wire logic [20:0]           stackTopEntry,
    input  wire logic                  lowIsrActive,
    input  wire logic                  wakeEvent,
    // datapath control
    output var bit_ctl_pkg::ctl_t      ctl,
    // wishbone slave
    input  wire logic                  wbCyc,
    input  wire logic                  wbStb,
    input  wire logic                  wbWe,
    input  wire logic [7:0]            wbAdr,
    input  wire logic [3:0]            wbSel,
    input  wire logic [31:0]           wbDatW,
    output logic [31:0]                wbDatR,
    output logic                       wbAck
);
    import bit_ctl_pkg::*;

    // complete module state
    typedef struct packed {
        state_t      fsm;
        logic [7:0]  jumpLow;
        logic        jumpFast;
        logic        jumpIsCall;
        logic [2:0]  ctrl;
        logic [15:0] retired;
        ctl_t        ctl;
        logic        wbAck;
        logic [31:0] wbDatR;
    } regs_t;

    regs_t q_reg;
    regs_t q_next;

    logic       condTrue;
    logic       bitIsSet;
    logic [7:0] rmwData;
    logic       execNow;

    // sign-extended word offset added to next counter
    function automatic logic [20:0] relTarget(input logic [20:0] pc, input logic [10:0] off);
        relTarget = pc + {{9{off[10]}}, off, 1'b0};
    endfunction

    // bit field change for clear, set, toggle
    function automatic logic [7:0] bitMask(input logic [2:0] idx);
        bitMask = 8'h01 << idx;
    endfunction

    // port reads take the pin levels
    assign rmwData = (instrWord[7:0] == PORT_B_ADDR && !instrWord[8]) ? portPins : fileRdData;
    assign execNow = q_reg.fsm == ST_EXEC && instrValid && q_reg.ctrl[CTRL_EN_BIT];

    cond_eval u_cond (
        .condSel  (instrWord[10:8]),
        .flags    (flags),
        .testData (rmwData),
        .bitIdx   (instrWord[11:9]),
        .condTrue (condTrue),
        .bitIsSet (bitIsSet)
    );

    // next state
    always_comb begin
        q_next = q_reg;
        q_next.ctl = '0;
        q_next.ctl.timeOutFlag = q_reg.ctl.timeOutFlag;
        q_next.ctl.powerDownFlag = q_reg.ctl.powerDownFlag;
        // wishbone access, one-cycle acknowledge
        q_next.wbAck = wbCyc && wbStb && !q_reg.wbAck;
        if (wbCyc && wbStb && !q_reg.wbAck) begin
            q_next.wbDatR = 32'h0000_0000;
            unique case (wbAdr)
                CTRL_OFS: begin
                    q_next.wbDatR[2:0] = q_reg.ctrl;
                    if (wbWe && wbSel[0]) begin
                        q_next.ctrl = wbDatW[2:0];
                    end
                end
                STAT_OFS: begin
                    q_next.wbDatR[3:0] = {q_reg.ctl.powerDownFlag, q_reg.ctl.timeOutFlag, q_reg.fsm};
                end
                RETIRE_OFS: begin
                    q_next.wbDatR[15:0] = q_reg.retired;
                end
                default: begin
                    q_next.wbDatR = 32'h0000_0000;
                end
            endcase
        end
        // instruction sequencing
        unique case (q_reg.fsm)
            ST_EXEC: begin
                if (execNow) begin
                    q_next.retired = q_reg.retired + 16'h0001;
                    unique casez (instrWord)
                        PAT_BIT_CLEAR, PAT_BIT_SET, PAT_BIT_TOGGLE: begin
                            q_next.ctl.fileWe = 1'b1;
                            q_next.ctl.fileAddr = instrWord[7:0];
                            q_next.ctl.accessSel = instrWord[8];
                            if (instrWord[15:12] == 4'h9) begin
                                q_next.ctl.fileWrData = rmwData & ~bitMask(instrWord[11:9]);
                            end else if (instrWord[15:12] == 4'h8) begin
                                q_next.ctl.fileWrData = rmwData | bitMask(instrWord[11:9]);
                            end else begin
                                q_next.ctl.fileWrData = rmwData ^ bitMask(instrWord[11:9]);
                            end
                            if (instrWord[7:0] == TIMER0_ADDR && !instrWord[8] && q_reg.ctrl[CTRL_PSA_BIT]) begin
                                q_next.ctl.prescalerClear = 1'b1;
                            end
                        end
                        PAT_SKIP_CLEAR: begin
                            if (!bitIsSet) begin
                                q_next.fsm = ST_FLUSH;
                            end
                        end
                        PAT_SKIP_SET: begin
                            if (bitIsSet) begin
                                q_next.fsm = ST_FLUSH;
                            end
                        end
                        PAT_COND_BRANCH: begin
                            if (condTrue) begin
                                q_next.ctl.pcLoad = 1'b1;
                                q_next.ctl.pcTarget = relTarget(pcNow, {{3{instrWord[7]}}, instrWord[7:0]});
                                q_next.fsm = ST_FLUSH;
                            end
                        end
                        PAT_CALL, PAT_JUMP: begin
                            q_next.jumpLow = instrWord[7:0];
                            q_next.jumpFast = instrWord[8] && !instrWord[9];
                            q_next.jumpIsCall = !instrWord[9] || !instrWord[8];
                            q_next.fsm = ST_WORD2;
                        end
                        PAT_REL_BRANCH, PAT_REL_CALL: begin
                            q_next.ctl.pcLoad = 1'b1;
                            q_next.ctl.pcTarget = relTarget(pcNow, instrWord[10:0]);
                            q_next.ctl.stackPush = instrWord[11];
                            q_next.ctl.pushValue = pcNow;
                            q_next.fsm = ST_FLUSH;
                        end
                        PAT_SECOND_WORD, OP_NOP: begin
                            q_next.ctl.nopCycle = 1'b1;
                        end
                        PAT_RET_LITERAL: begin
                            q_next.ctl.wregLoad = 1'b1;
                            q_next.ctl.wregValue = instrWord[7:0];
                            q_next.ctl.stackPop = 1'b1;
                            q_next.ctl.pcLoad = 1'b1;
                            q_next.ctl.pcTarget = stackTopEntry;
                            q_next.fsm = ST_FLUSH;
                        end
                        PAT_IRQ_RETURN, PAT_SUB_RETURN: begin
                            q_next.ctl.stackPop = 1'b1;
                            q_next.ctl.pcLoad = 1'b1;
                            q_next.ctl.pcTarget = stackTopEntry;
                            q_next.ctl.fastRestore = instrWord[0];
                            if (!instrWord[1]) begin
                                if (q_reg.ctrl[CTRL_PRIO_BIT] && lowIsrActive) begin
                                    q_next.ctl.lowIrqEnableSet = 1'b1;
                                end else begin
                                    q_next.ctl.highIrqEnableSet = 1'b1;
                                end
                            end
                            q_next.fsm = ST_FLUSH;
                        end
                        OP_POP: begin
                            q_next.ctl.stackPop = 1'b1;
                        end
                        OP_PUSH: begin
                            q_next.ctl.stackPush = 1'b1;
                            q_next.ctl.pushValue = pcNow;
                        end
                        OP_SLEEP: begin
                            q_next.ctl.sleepEnter = 1'b1;
                            q_next.ctl.flagWrite = 1'b1;
                            q_next.ctl.timeOutFlag = 1'b1;
                            q_next.ctl.powerDownFlag = 1'b0;
                            q_next.fsm = ST_SLEEP;
                        end
                        OP_WDT_CLEAR: begin
                            q_next.ctl.watchdogClear = 1'b1;
                            q_next.ctl.flagWrite = 1'b1;
                            q_next.ctl.timeOutFlag = 1'b1;
                            q_next.ctl.powerDownFlag = 1'b1;
                        end
                        OP_DEC_ADJUST: begin
                            q_next.ctl.decimalAdjust = 1'b1;
                        end
                        OP_SOFT_RESET: begin
                            q_next.ctl.softReset = 1'b1;
                            q_next.ctl.flagWrite = 1'b1;
                            q_next.ctl.timeOutFlag = FLAG_RESET;
                            q_next.ctl.powerDownFlag = FLAG_RESET;
                        end
                        default: begin
                            q_next.retired = q_reg.retired;
                        end
                    endcase
                end
            end
            ST_FLUSH: begin
                // discard the prefetched or skipped word
                if (instrValid) begin
                    q_next.ctl.nopCycle = 1'b1;
                    q_next.fsm = ST_EXEC;
                end
            end
            ST_WORD2: begin
                if (instrValid) begin
                    q_next.fsm = ST_EXEC;
                    q_next.retired = q_reg.retired + 16'h0001;
                    if (instrWord[15:12] == 4'hF) begin
                        q_next.ctl.pcLoad = 1'b1;
                        q_next.ctl.pcTarget = {instrWord[11:0], q_reg.jumpLow, 1'b0};
                        q_next.ctl.stackPush = q_reg.jumpIsCall;
                        q_next.ctl.pushValue = pcNow;
                        q_next.ctl.fastSave = q_reg.jumpFast;
                        q_next.fsm = ST_FLUSH;
                    end else begin
                        q_next.ctl.nopCycle = 1'b1;
                    end
                end
            end
            ST_SLEEP: begin
                if (wakeEvent) begin
                    q_next.fsm = ST_EXEC;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q_reg <= '0;
            q_reg.ctrl <= CTRL_RESET;
            q_reg.ctl.timeOutFlag <= FLAG_RESET;
            q_reg.ctl.powerDownFlag <= FLAG_RESET;
        end else begin
            q_reg <= q_next;
        end
    end

    // outputs straight from the state register
    assign ctl = q_reg.ctl;
    assign wbAck = q_reg.wbAck;
    assign wbDatR = q_reg.wbDatR;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_skip_clear;
        execNow && instrWord[15:12] == 4'hB |=> (q_reg.fsm == ST_FLUSH) == !$past(bitIsSet);
    endproperty
    a_skip_clear: assert property (p_skip_clear)
        else $error("skip-if-clear outcome wrong");

    property p_skip_set;
        execNow && instrWord[15:12] == 4'hA && bitIsSet |=> q_reg.fsm == ST_FLUSH && !ctl.pcLoad;
    endproperty
    a_skip_set: assert property (p_skip_set)
        else $error("skip-if-set did not skip");

    property p_cond_branch;
        execNow && instrWord[15:11] == 5'b11100
            |=> ctl.pcLoad == $past(condTrue)
                && (!ctl.pcLoad || ctl.pcTarget == $past(pcNow) + {{12{$past(instrWord[7])}}, $past(instrWord[7:0]), 1'b0});
    endproperty
    a_cond_branch: assert property (p_cond_branch)
        else $error("conditional branch target or decision wrong");

    property p_call;
        execNow && instrWord[15:9] == 7'b1110110 ##1 instrValid && instrWord[15:12] == 4'hF
            |=> ctl.pcLoad && ctl.stackPush && ctl.fastSave == $past(instrWord[8], 2);
    endproperty
    a_call: assert property (p_call)
        else $error("call second word not consumed");

    property p_jump;
        execNow && instrWord[15:8] == 8'hEF ##1 instrValid && instrWord[15:12] == 4'hF
            |=> ctl.pcLoad && !ctl.stackPush && ctl.pcTarget[8:1] == $past(instrWord[7:0], 2);
    endproperty
    a_jump: assert property (p_jump)
        else $error("jump target wrong");

    property p_lone_second;
        execNow && instrWord[15:12] == 4'hF |=> ctl.nopCycle && !ctl.pcLoad && !ctl.fileWe && q_reg.fsm == ST_EXEC;
    endproperty
    a_lone_second: assert property (p_lone_second)
        else $error("lone second word not a no-op");

    property p_pop;
        execNow && instrWord == OP_POP |=> ctl.stackPop && !ctl.flagWrite && !ctl.pcLoad;
    endproperty
    a_pop: assert property (p_pop)
        else $error("pop misdecoded");

    property p_push;
        execNow && instrWord == OP_PUSH |=> ctl.stackPush && ctl.pushValue == $past(pcNow) && !ctl.flagWrite;
    endproperty
    a_push: assert property (p_push)
        else $error("push value wrong");

    property p_irq_return;
        execNow && instrWord[15:1] == 15'h0008 && !q_reg.ctrl[CTRL_PRIO_BIT]
            |=> ctl.highIrqEnableSet && ctl.stackPop && q_reg.fsm == ST_FLUSH;
    endproperty
    a_irq_return: assert property (p_irq_return)
        else $error("interrupt return sequence wrong");

    property p_ret_literal;
        execNow && instrWord[15:8] == 8'h0C |=> ctl.wregLoad && ctl.wregValue == $past(instrWord[7:0]) && ctl.stackPop;
    endproperty
    a_ret_literal: assert property (p_ret_literal)
        else $error("literal return wrong");

    property p_sleep;
        execNow && instrWord == OP_SLEEP |=> ctl.sleepEnter && ctl.timeOutFlag && !ctl.powerDownFlag;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("standby flags wrong");

    property p_pc_flush;
        ctl.pcLoad |-> q_reg.fsm == ST_FLUSH;
    endproperty
    a_pc_flush: assert property (p_pc_flush)
        else $error("counter change without flush cycle");

    property p_port_pins;
        execNow && instrWord[15:12] == 4'h8 && instrWord[8:0] == {1'b0, PORT_B_ADDR}
            |=> ctl.fileWrData == ($past(portPins) | bitMask($past(instrWord[11:9])));
    endproperty
    a_port_pins: assert property (p_port_pins)
        else $error("port write-back not from pins");

    property p_prescaler;
        execNow && instrWord[15:12] == 4'h9 && instrWord[8:0] == {1'b0, TIMER0_ADDR}
            |=> ctl.prescalerClear == $past(q_reg.ctrl[CTRL_PSA_BIT]);
    endproperty
    a_prescaler: assert property (p_prescaler)
        else $error("prescaler clear wrong");

endmodule
`default_nettype wire

/* bench/prog_mem_model.sv */
// program memory model feeding instruction words to the decoder
`timescale 1ns/10ps
`default_nettype none

module prog_mem_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // fetch control from bench and decoder
    input  wire logic        run,
    input  wire logic        stall,
    input  wire logic        pcLoad,
    input  wire logic [20:0] pcTarget,
    // word stream
    output logic             instrValid,
    output logic [15:0]      instrWord,
    output logic [20:0]      pcNow
);
    logic [15:0] mem [0:63];
    logic [19:0] idx_reg;
    logic [15:0] last_reg;
    // a stalled cycle shows a changing pattern; while idle, no-ops drain a pending flush
    assign instrValid = ~(stall & run);
    assign instrWord  = !instrValid ? ~last_reg : run ? mem[idx_reg[5:0]] : 16'h0000;
    assign pcNow      = {idx_reg + 20'h0_0001, 1'b0};
    // word index follows the sequence or a loaded target
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idx_reg  <= '0;
            last_reg <= '0;
        end else begin
            last_reg <= instrWord;
            if (!run) begin
                idx_reg <= '0;
            end else if (pcLoad) begin
                idx_reg <= pcTarget[20:1];
            end else if (instrValid) begin
                idx_reg <= idx_reg + 20'h0_0001;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/bit_and_control_op_decoder_bench.sv */
// self-checking bench for the bit and control decoder
`timescale 1ns/10ps
`default_nettype none

module bit_and_control_op_decoder_bench;
    import bit_ctl_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, run = 1'b0, stall = 1'b0, wakeEvent = 1'b0, lowIsrActive = 1'b0;
    logic [3:0]  wbSel = '0;
    logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, instrValid, wbAck, skip;
    logic [15:0] instrWord, w, w2;
    logic [20:0] pcNow, stackTopEntry = '0;
    logic [7:0]  fileRdData = '0, portPins = '0, wbAdr = '0;
    logic [31:0] wbDatW = '0, wbDatR, q;
    flags_t      flags = '0;
    ctl_t        ctl, got;
    int          errTotal = 0, nTests = 0;

    prog_mem_model pm_u (.clk(clk), .rstn(rstn), .run(run), .stall(stall), .pcLoad(ctl.pcLoad),
        .pcTarget(ctl.pcTarget), .instrValid(instrValid), .instrWord(instrWord), .pcNow(pcNow));
    bit_ctl_decoder dut_u (.clk(clk), .rstn(rstn), .instrValid(instrValid), .instrWord(instrWord),
        .pcNow(pcNow), .flags(flags), .fileRdData(fileRdData), .portPins(portPins),
        .stackTopEntry(stackTopEntry), .lowIsrActive(lowIsrActive), .wakeEvent(wakeEvent), .ctl(ctl),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
        .wbDatR(wbDatR), .wbAck(wbAck));

    // clock and random fetch stalls
    initial forever #25 clk = ~clk;
    always @(posedge clk) stall <= ($urandom_range(3) == 0);

    // expected bit-op result, pins replace the file value for port b
    function automatic logic [7:0] bitExp(logic [15:0] x, logic [7:0] rd, logic [7:0] pins);
        logic [7:0] s;
        logic [7:0] m;
        s = (x[8:0] == {1'b0, PORT_B_ADDR}) ? pins : rd;
        m = 8'h01 << x[11:9];
        return (x[15:12] == 4'h9) ? (s & ~m) : (x[15:12] == 4'h8) ? (s | m) : (s ^ m);
    endfunction
    // branch condition: zero, carry, overflow, negative, odd code inverts
    function automatic logic taken(logic [2:0] c, flags_t f);
        logic [3:0] v;
        v = {f.neg, f.ovf, f.carry, f.zero};
        return v[c[2:1]] ^ c[0];
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            errTotal++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // classic single wishbone cycle, waits for ack
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbSel <= 4'hF;
        wbAdr <= adr;
        wbDatW <= d;
        do @(posedge clk); while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
    endtask
    // runs two words from memory start, keeps the first of each control pulse
    task automatic runp(input logic [15:0] a, input logic [15:0] b);
        pm_u.mem[0] = a;
        pm_u.mem[1] = b;
        got = '0;
        run <= 1'b1;
        repeat (14) begin
            @(posedge clk);
            if (ctl.fileWe && !got.fileWe) got.fileWrData = ctl.fileWrData;
            if (ctl.pcLoad && !got.pcLoad) got.pcTarget = ctl.pcTarget;
            if (ctl.stackPush && !got.stackPush) got.pushValue = ctl.pushValue;
            if (ctl.wregLoad && !got.wregLoad) got.wregValue = ctl.wregValue;
            got = got | (ctl & {1'b1, 8'h00, 1'b1, 8'h00, 1'b1, 21'h0, 1'b1, 1'b1, 21'h0, 1'b1, 1'b1,
                1'b1, 8'h00, {11{1'b1}}});
        end
        run <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic testDone;
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #400_000;
        errTotal++;
        testDone();
    end
    // main sequence
    initial begin
        void'($urandom(32'h0000_0e57));
        for (int i = 0; i < 64; i++) pm_u.mem[i] = 16'h0000;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        wb(1'b0, STAT_OFS, 0); chk(q, 32'h0000_000C);
        wb(1'b1, CTRL_OFS, 32'h0000_0003); wb(1'b1, 8'h40, 0); wb(1'b0, CTRL_OFS, 0); chk(q, 3);
        for (int i = 0; i < 24; i++) begin
            w = {(i % 3 == 0) ? 4'h9 : (i % 3 == 1) ? 4'h8 : 4'h7, 12'($urandom)};
            if (i % 4 > 1) w[8:0] = {1'b0, (i % 4 == 2) ? TIMER0_ADDR : PORT_B_ADDR};
            fileRdData <= 8'($urandom); portPins <= 8'($urandom); @(posedge clk); runp(w, 0);
            chk({got.fileWe, got.pcLoad, got.flagWrite}, 3'b100);
            chk(got.fileWrData, bitExp(w, fileRdData, portPins));
            chk(got.prescalerClear, w[8:0] == {1'b0, TIMER0_ADDR});
        end
        for (int i = 0; i < 16; i++) begin
            w = {4'hA + 4'(i % 2), 3'($urandom), 1'b1, 8'($urandom)};
            fileRdData <= 8'($urandom); flags <= 4'($urandom); @(posedge clk); runp(w, 16'h8123);
            skip = fileRdData[w[11:9]] ^ w[12];
            chk({got.fileWe, got.pcLoad}, {!skip, 1'b0});
            w = {5'b1110_0, 3'(i), 8'($urandom)}; runp(w, 0);
            chk(got.pcLoad, taken(w[10:8], flags));
            if (got.pcLoad) chk(got.pcTarget, 21'd2 + {{12{w[7]}}, w[7:0], 1'b0});
            w = {4'hD, 1'(i), 11'($urandom)}; runp(w, 0);
            chk({got.pcTarget, got.stackPush}, {21'd2 + {{9{w[10]}}, w[10:0], 1'b0}, 1'(i)});
            w2 = {4'hF, 12'($urandom)}; runp(w2, 0); chk({got.pcLoad, got.fileWe}, 0);
            w = (i % 3 == 0) ? {8'hEF, 8'($urandom)} : {7'b1110_110, 1'(i), 8'($urandom)}; runp(w, w2);
            chk(got.pcTarget, {w2[11:0], w[7:0], 1'b0});
            chk({got.stackPush, got.fastSave}, {i % 3 != 0, i % 3 != 0 && i % 2 == 1});
        end
        runp(OP_PUSH, 0); chk({got.stackPush, got.pushValue, got.flagWrite}, {1'b1, 21'd2, 1'b0});
        runp(OP_POP, 0); chk({got.stackPop, got.flagWrite}, 2'b10);
        stackTopEntry <= 21'($urandom); @(posedge clk); w = {8'h0C, 8'($urandom)}; runp(w, 0);
        chk({got.wregLoad, got.wregValue, got.stackPop, got.pcTarget}, {1'b1, w[7:0], 1'b1, stackTopEntry});
        runp(16'h0011, 0); chk({got.highIrqEnableSet, got.fastRestore, got.pcLoad}, 3'b111);
        wb(1'b1, CTRL_OFS, 32'h0000_0007); lowIsrActive <= 1'b1; runp(16'h0010, 0);
        chk({got.lowIrqEnableSet, got.highIrqEnableSet}, 2'b10);
        runp(OP_SLEEP, 0); chk(got.sleepEnter, 1); wb(1'b0, STAT_OFS, 0); chk(q, 32'h0000_0007);
        wakeEvent <= 1'b1; @(posedge clk); wakeEvent <= 1'b0; @(posedge clk);
        runp(OP_WDT_CLEAR, 0); wb(1'b0, STAT_OFS, 0); chk(got.watchdogClear, 1); chk(q, 32'h0000_000C);
        runp(OP_DEC_ADJUST, 0); chk(got.decimalAdjust, 1);
        runp(OP_SOFT_RESET, 0); chk(got.softReset, 1);
        testDone();
    end
endmodule
`default_nettype wire
